// File: nfh_pkg.sv
// Package of constants, types and codes for the NOR flash host controller
package nfh_pkg;

  // Bus and pin widths
  localparam int FA_W = 21;
  localparam int AV_W = 5;

  // Register byte offsets
  localparam logic [AV_W-1:0] OFS_CMD = 5'h00;
  localparam logic [AV_W-1:0] OFS_ADDR = 5'h04;
  localparam logic [AV_W-1:0] OFS_WDATA = 5'h08;
  localparam logic [AV_W-1:0] OFS_STATUS = 5'h0C;
  localparam logic [AV_W-1:0] OFS_RDATA = 5'h10;

  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_TOUT_BIT = 2;

  // Reset values
  localparam logic [FA_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Command cycle addresses and codes
  localparam logic [FA_W-1:0] CA_5555 = 21'h005555;
  localparam logic [FA_W-1:0] CA_2AAA = 21'h002AAA;
  localparam logic [7:0] CD_AA = 8'hAA;
  localparam logic [7:0] CD_55 = 8'h55;
  localparam logic [7:0] CD_PROG = 8'hA0;
  localparam logic [7:0] CD_ERASE = 8'h80;
  localparam logic [7:0] CD_ID = 8'h90;
  localparam logic [7:0] CD_QUERY = 8'h98;
  localparam logic [7:0] CD_EXIT = 8'hF0;
  localparam logic [7:0] CD_SECT = 8'h30;
  localparam logic [7:0] CD_BLOCK = 8'h50;
  localparam logic [7:0] CD_CHIP = 8'h10;

  // Erase address masks: sector keeps A20..A12, block keeps A20..A16
  localparam logic [FA_W-1:0] SECT_MASK = 21'h1FF000;
  localparam logic [FA_W-1:0] BLOCK_MASK = 21'h1F0000;

  // Bit positions of the status bits on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  // Timing, figures in ns, counts in ref_clk cycles
  localparam int CLK_NS = 10;
  localparam int T_AS_NS = 10;
  localparam int T_WP_NS = 40;
  localparam int T_WPH_NS = 30;
  localparam int T_RC_NS = 90;
  localparam int T_PROG_NS = 20000;
  localparam int SYNC_CYC = 2;
  localparam logic [15:0] AS_CYC = 16'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WP_CYC = 16'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WPH_CYC = 16'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RD_CYC =
    16'((T_RC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1);
  localparam logic [23:0] PROG_TOUT_CYC = 24'(T_PROG_NS / CLK_NS);
  localparam logic [23:0] ERASE_TOUT_DEF = 24'h989680;

  // Operations that software launches through the command register
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT = 3'b010,
    OP_BLOCK = 3'b011,
    OP_CHIP = 3'b100,
    OP_ID = 3'b101,
    OP_QUERY = 3'b110,
    OP_EXIT = 3'b111
  } nfh_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WSET = 3'b001,
    S_WLOW = 3'b010,
    S_WREC = 3'b011,
    S_RACC = 3'b100,
    S_STEP = 3'b101
  } nfh_state_t;

  // Avalon-MM slave request and answer
  typedef struct packed {
    logic [AV_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } nfh_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } nfh_avs_rsp_t;

  // Flash pins driven by the controller
  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } nfh_pins_t;

  // One bus write of a command sequence
  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [7:0] data;
  } nfh_bw_t;

endpackage

// File: nfh_ctrl.sv
// Host controller that drives a parallel NOR flash from Avalon-MM registers
module nfh_ctrl
  import nfh_pkg::*;
#(
  parameter logic [23:0] ERASE_TOUT_CYC = ERASE_TOUT_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire nfh_avs_req_t avs_req,
  output nfh_avs_rsp_t avs_rsp,
  output nfh_pins_t flash,
  input wire logic [7:0] dq_in
);

  typedef struct packed {
    nfh_state_t st;
    nfh_op_t op;
    logic [2:0] idx;
    logic [15:0] cnt;
    logic [23:0] tout;
    logic rd_phase;
    logic first;
    logic npoll;
    logic prev6;
    logic busy;
    logic done;
    logic err;
    logic [FA_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] smp;
    logic [7:0] s1;
    logic [7:0] s2;
    nfh_pins_t pins;
    nfh_avs_rsp_t rsp;
  } nfh_regs_t;

  nfh_regs_t r_reg;
  nfh_regs_t r_next;

  // Number of bus writes in the sequence of an operation
  function automatic logic [2:0] seq_len(input nfh_op_t op);
    unique case (op)
      OP_READ: seq_len = 3'd0;
      OP_PROG: seq_len = 3'd4;
      OP_SECT, OP_BLOCK, OP_CHIP: seq_len = 3'd6;
      OP_ID, OP_QUERY, OP_EXIT: seq_len = 3'd3;
    endcase
  endfunction

  // Address and data of write number idx of an operation
  function automatic nfh_bw_t seq_word(input nfh_op_t op,
                                       input logic [2:0] idx,
                                       input logic [FA_W-1:0] a,
                                       input logic [7:0] d);
    nfh_bw_t w;
    w.addr = CA_5555;
    w.data = CD_AA;
    unique case (idx)
      3'd0: w = '{CA_5555, CD_AA};
      3'd1: w = '{CA_2AAA, CD_55};
      3'd2: begin
        unique case (op)
          OP_PROG: w.data = CD_PROG;
          OP_ID: w.data = CD_ID;
          OP_QUERY: w.data = CD_QUERY;
          OP_EXIT: w.data = CD_EXIT;
          default: w.data = CD_ERASE;
        endcase
      end
      3'd3: begin
        if (op == OP_PROG) begin
          w = '{a, d};
        end else begin
          w = '{CA_5555, CD_AA};
        end
      end
      3'd4: w = '{CA_2AAA, CD_55};
      default: begin
        unique case (op)
          OP_SECT: w = '{a & SECT_MASK, CD_SECT};
          OP_BLOCK: w = '{a & BLOCK_MASK, CD_BLOCK};
          default: w = '{CA_5555, CD_CHIP};
        endcase
      end
    endcase
    seq_word = w;
  endfunction

  nfh_bw_t cur_w;
  logic is_wr_op;
  logic [23:0] tout_lim;

  // Sequence word and polling limits of the current operation
  always_comb begin
    cur_w = seq_word(r_reg.op, r_reg.idx, r_reg.addr, r_reg.wdata);
    is_wr_op = (r_reg.op != OP_READ) && (r_reg.op != OP_ID) &&
               (r_reg.op != OP_QUERY) && (r_reg.op != OP_EXIT);
    tout_lim = (r_reg.op == OP_PROG) ? PROG_TOUT_CYC : ERASE_TOUT_CYC;
  end

  // Next state: bus slave first, so the engine's flag sets win over clears
  always_comb begin
    r_next = r_reg;
    r_next.s1 = dq_in;
    r_next.s2 = r_reg.s1;
    r_next.rsp.waitrequest = 1'b1;

    // One wait cycle per access, then a single low-waitrequest cycle
    if ((avs_req.read || avs_req.write) && r_reg.rsp.waitrequest) begin
      r_next.rsp.waitrequest = 1'b0;
      r_next.rsp.readdata = 32'h00000000;
      if (avs_req.write) begin
        unique case (avs_req.address)
          OFS_CMD: begin
            // Launches are refused while busy, exit included
            if (!r_reg.busy) begin
              r_next.op = nfh_op_t'(avs_req.writedata[2:0]);
              r_next.idx = 3'd0;
              r_next.cnt = 16'h0000;
              r_next.tout = 24'h000000;
              r_next.busy = 1'b1;
              r_next.done = 1'b0;
              r_next.err = 1'b0;
              r_next.first = 1'b1;
              r_next.npoll = 1'b0;
              if (avs_req.writedata[2:0] == OP_READ) begin
                r_next.rd_phase = 1'b1;
                r_next.st = S_RACC;
              end else begin
                r_next.rd_phase = 1'b0;
                r_next.st = S_WSET;
              end
            end
          end
          OFS_ADDR: r_next.addr = avs_req.writedata[FA_W-1:0];
          OFS_WDATA: r_next.wdata = avs_req.writedata[7:0];
          OFS_STATUS: begin
            if (avs_req.writedata[ST_DONE_BIT]) begin
              r_next.done = 1'b0;
            end
            if (avs_req.writedata[ST_TOUT_BIT]) begin
              r_next.err = 1'b0;
            end
          end
          default: ;
        endcase
      end else begin
        unique case (avs_req.address)
          OFS_CMD: r_next.rsp.readdata[2:0] = r_reg.op;
          OFS_ADDR: r_next.rsp.readdata[FA_W-1:0] = r_reg.addr;
          OFS_WDATA: r_next.rsp.readdata[7:0] = r_reg.wdata;
          OFS_STATUS: begin
            r_next.rsp.readdata[ST_BUSY_BIT] = r_reg.busy;
            r_next.rsp.readdata[ST_DONE_BIT] = r_reg.done;
            r_next.rsp.readdata[ST_TOUT_BIT] = r_reg.err;
          end
          OFS_RDATA: r_next.rsp.readdata[7:0] = r_reg.rdata;
          default: ;
        endcase
      end
    end

    if (r_reg.rd_phase && is_wr_op) begin
      r_next.tout = r_reg.tout + 24'h000001;
    end

    unique case (r_reg.st)
      S_IDLE: ;
      // Address and data out, select low, gate held high
      S_WSET: begin
        r_next.pins.addr = cur_w.addr;
        r_next.pins.dq_o = cur_w.data;
        r_next.pins.dq_oe = 1'b1;
        r_next.pins.ce_n = 1'b0;
        r_next.pins.oe_n = 1'b1;
        r_next.pins.we_n = 1'b1;
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt >= AS_CYC) begin
          r_next.cnt = 16'h0000;
          r_next.st = S_WLOW;
        end
      end
      // Strobe held low well past the glitch filter
      S_WLOW: begin
        r_next.pins.we_n = 1'b0;
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt >= WP_CYC) begin
          r_next.cnt = 16'h0000;
          r_next.pins.we_n = 1'b1;
          r_next.pins.ce_n = 1'b1;
          r_next.st = S_WREC;
        end
      end
      // Data held past the rising strobe, then released
      S_WREC: begin
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt >= WPH_CYC) begin
          r_next.cnt = 16'h0000;
          r_next.pins.dq_oe = 1'b0;
          r_next.st = S_STEP;
        end
      end
      // Read: release the bus before opening the gate
      S_RACC: begin
        r_next.pins.addr = r_reg.addr;
        r_next.pins.dq_oe = 1'b0;
        r_next.pins.ce_n = 1'b0;
        r_next.pins.oe_n = 1'b0;
        r_next.pins.we_n = 1'b1;
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt >= RD_CYC) begin
          r_next.cnt = 16'h0000;
          r_next.smp = r_reg.s2;
          r_next.pins.ce_n = 1'b1;
          r_next.pins.oe_n = 1'b1;
          r_next.st = S_STEP;
        end
      end
      S_STEP: begin
        if (!r_reg.rd_phase) begin
          if (r_reg.idx < seq_len(r_reg.op) - 3'd1) begin
            r_next.idx = r_reg.idx + 3'd1;
            r_next.st = S_WSET;
          end else if (is_wr_op) begin
            // Status polling starts only after the last strobe
            r_next.rd_phase = 1'b1;
            r_next.st = S_RACC;
          end else begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
            r_next.st = S_IDLE;
          end
        end else begin
          r_next.rdata = r_reg.smp;
          r_next.prev6 = r_reg.smp[TOGGLE_BIT];
          r_next.first = 1'b0;
          r_next.st = S_RACC;
          if (!is_wr_op) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
            r_next.rd_phase = 1'b0;
            r_next.st = S_IDLE;
          end else if (r_reg.tout >= tout_lim) begin
            // Gives up; the flash state is unknown, software decides
            r_next.err = 1'b1;
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
            r_next.rd_phase = 1'b0;
            r_next.st = S_IDLE;
          end else if (!r_reg.first &&
                       r_reg.smp[TOGGLE_BIT] == r_reg.prev6) begin
            // Two stable pairs in a row guard against a racing read
            r_next.npoll = 1'b1;
            if (r_reg.npoll) begin
              r_next.busy = 1'b0;
              r_next.done = 1'b1;
              r_next.rd_phase = 1'b0;
              r_next.st = S_IDLE;
            end
          end else begin
            r_next.npoll = 1'b0;
          end
        end
      end
      default: r_next.st = S_IDLE;
    endcase
  end

  // Single state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.addr <= ADDR_RST;
      r_reg.wdata <= DATA_RST;
      r_reg.pins.ce_n <= 1'b1;
      r_reg.pins.oe_n <= 1'b1;
      r_reg.pins.we_n <= 1'b1;
      r_reg.rsp.waitrequest <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_rsp = r_reg.rsp;
  assign flash = r_reg.pins;

endmodule

// File: nfh_props.sv
// Checker of the flash host controller pin and bus timing
module nfh_props
  import nfh_pkg::*;
#(
  parameter logic [23:0] ERASE_TOUT_CYC = ERASE_TOUT_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire nfh_avs_req_t avs_req,
  input wire nfh_avs_rsp_t avs_rsp,
  input wire nfh_pins_t flash,
  input wire logic [7:0] dq_in
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Strobe low 40 ns, well clear of the glitch filter
  sequence s_we_low;
    !flash.we_n [*4];
  endsequence
  // Bus request still waiting for its answer
  sequence s_req;
    (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
  endsequence
  a_we_wide: assert property ($fell(flash.we_n) |-> s_we_low)
    else $error("write strobe too short");
  a_write_gate: assert property (
    !flash.we_n |-> !flash.ce_n && flash.oe_n && flash.dq_oe)
    else $error("write without select or with gate low");
  a_read_float: assert property (
    !flash.oe_n |-> !flash.dq_oe && flash.we_n)
    else $error("bus driven during a read");
  a_data_held: assert property (
    !flash.we_n && !$past(flash.we_n) |->
    $stable(flash.dq_o) && $stable(flash.addr))
    else $error("address or data moved under the strobe");
  a_strobe_end: assert property (
    $rose(flash.we_n) |-> flash.ce_n)
    else $error("select kept after strobe release");
  a_idle_sel: assert property (
    flash.ce_n |-> flash.we_n && flash.oe_n)
    else $error("strobe or gate active while deselected");
  a_read_len: assert property (
    $fell(flash.oe_n) |-> !flash.oe_n [*8])
    else $error("read phase shorter than a read cycle");
  a_wait_ack: assert property (s_req |=> !avs_rsp.waitrequest)
    else $error("bus request not answered after one wait");
  a_ack_single: assert property (
    !avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("bus answer longer than one cycle");
endmodule

// File: nfh_flash_model.sv
// Behavioural model of the parallel flash on the far side
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int PROG_CYC = 100,
  parameter int ERASE_CYC = 40,
  parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic slow,
  input wire nfh_pins_t flash,
  output logic [7:0] dq_in = 8'h00
);
  logic [7:0] mem [int];
  logic [7:0] pv = 8'h00;
  logic [7:0] last = 8'h00;
  logic ers = 1'b0;
  logic tg = 1'b0;
  int step = 0;
  int busy = 0;
  int mode = 0;
  nfh_pins_t p = '1;

  // Read value: status while busy, else mode data
  function automatic logic [7:0] rd(input logic [FA_W-1:0] a);
    if (busy > 0) return {ers ? 1'b0 : ~pv[7], tg, 6'h00};
    if (mode == 1) return a[0] ? DEV_CODE : MFR_CODE;
    if (mode == 2) return a == 21'h10 ? 8'h51 : 8'h59;
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Command decoder; any wrong byte restarts the sequence and keeps the current mode
  task automatic wr(input logic [FA_W-1:0] a, input logic [7:0] d);
    logic [FA_W-1:0] m;
    m = (d == CD_SECT) ? SECT_MASK : BLOCK_MASK;
    case (step)
      0, 4: step = (a == CA_5555 && d == CD_AA) ? step + 1 : 0;
      1, 5: step = (a == CA_2AAA && d == CD_55) ? step + 1 : 0;
      2: begin
        step = a != CA_5555 ? 0 : d == CD_PROG ? 3 : d == CD_ERASE ? 4 : 0;
        if (a == CA_5555 && d == CD_ID) mode = 1;
        if (a == CA_5555 && d == CD_QUERY) mode = 2;
        if (a == CA_5555 && d == CD_EXIT) mode = 0;
      end
      3: begin
        mem[a] = d;
        pv = d;
        ers = 1'b0;
        busy = PROG_CYC;
        step = 0;
      end
      default: begin
        ers = 1'b1;
        busy = slow ? 15 * ERASE_CYC : ERASE_CYC;
        if (d == CD_SECT || d == CD_BLOCK) begin
          foreach (mem[k]) if ((21'(k) & m) == (a & m)) mem[k] = 8'hFF;
        end else if (d == CD_CHIP && a == CA_5555) begin
          mem.delete();
        end else begin
          busy = 0;
        end
        step = 0;
      end
    endcase
  endtask

  // Pins sampled each edge; released bus shows a changing pattern
  always @(posedge ref_clk) begin
    if (busy > 0) busy--;
    if (!p.we_n && flash.we_n && !p.ce_n && p.oe_n && busy == 0) wr(p.addr, p.dq_o);
    if (!flash.ce_n && !flash.oe_n && (p.ce_n || p.oe_n) && busy > 0) tg = !tg;
    last = (!flash.ce_n && !flash.oe_n) ? rd(flash.addr) : ~last;
    dq_in <= last;
    p = flash;
  end
endmodule

// File: test_nor_flash_status_protect_id.sv
// Top bench: controller, flash model, register scenarios
bind nfh_ctrl nfh_props #(.ERASE_TOUT_CYC(ERASE_TOUT_CYC)) u_props (
  .ref_clk(ref_clk), .rst(rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
  .flash(flash), .dq_in(dq_in));

module test_nor_flash_status_protect_id
  import nfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    nfh_op_t op;
    logic [FA_W-1:0] a;
    logic [7:0] d;
    logic [7:0] rd;
  } nfh_row_t;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value
  localparam logic [31:0] DONE = 32'h1 << ST_DONE_BIT;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  nfh_avs_req_t req = '0;
  nfh_avs_rsp_t rsp;
  nfh_pins_t pins;
  logic [7:0] dq;
  logic [31:0] q;
  int err_total = 0;
  int compares = 0;
  // Operation, address, data, expected last byte
  nfh_row_t rows [19] = '{
    '{OP_PROG, 21'h00123, 8'h5A, 8'h5A}, '{OP_PROG, 21'h01123, 8'hA5, 8'hA5},
    '{OP_SECT, 21'h00FFF, 8'h00, 8'hFF}, '{OP_READ, 21'h00123, 8'h00, 8'hFF},
    '{OP_READ, 21'h01123, 8'h00, 8'hA5}, '{OP_PROG, 21'h10456, 8'h3C, 8'h3C},
    '{OP_BLOCK, 21'h1F000, 8'h00, 8'hFF}, '{OP_READ, 21'h10456, 8'h00, 8'hFF},
    '{OP_CHIP, 21'h00000, 8'h00, 8'hFF}, '{OP_READ, 21'h01123, 8'h00, 8'hFF},
    '{OP_ID, 21'h00000, 8'h00, 8'hFF}, '{OP_READ, 21'h00000, 8'h00, MFR},
    '{OP_READ, 21'h00001, 8'h00, DEV}, '{OP_EXIT, 21'h00000, 8'h00, DEV},
    '{OP_READ, 21'h00000, 8'h00, 8'hFF}, '{OP_QUERY, 21'h0, 8'h00, 8'hFF},
    '{OP_READ, 21'h00010, 8'h00, 8'h51}, '{OP_EXIT, 21'h00000, 8'h00, 8'h51},
    '{OP_READ, 21'h00010, 8'h00, 8'hFF}};

  nfh_ctrl #(.ERASE_TOUT_CYC(24'h0000C8)) dut (.ref_clk(ref_clk), .rst(rst),
    .avs_req(req), .avs_rsp(rsp), .flash(pins), .dq_in(dq));
  nfh_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) far (
    .ref_clk(ref_clk), .slow(slow), .flash(pins), .dq_in(dq));

  initial forever #5 ref_clk = ~ref_clk;

  task close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low
  task bus(input logic w, input logic [AV_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{address: a, read: !w, write: w, writedata: d};
    @(negedge ref_clk);
    while (rsp.waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        close_out();
      end
      @(negedge ref_clk);
    end
    q = rsp.readdata;
    @(posedge ref_clk);
    req <= '0;
  endtask

  // Status polling until busy drops, bounded
  task poll;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
      if (n > 1000) begin
        err_total++;
        close_out();
      end
    end while (q[ST_BUSY_BIT] !== 1'b0);
  endtask

  task op(input nfh_op_t o, input logic [FA_W-1:0] a, input logic [7:0] d);
    bus(1'b1, OFS_ADDR, 32'(a));
    bus(1'b1, OFS_WDATA, 32'(d));
    bus(1'b1, OFS_CMD, 32'(o));
    poll();
  endtask

  initial begin
    int n;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, q);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk("rdata reset", 32'h0, q);
    foreach (rows[i]) begin
      op(rows[i].op, rows[i].a, rows[i].d);
      chk("status", DONE, q);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk("rdata", 32'(rows[i].rd), q);
    end
    // Second launch while busy must be dropped
    bus(1'b1, OFS_ADDR, 32'h200);
    bus(1'b1, OFS_WDATA, 32'h77);
    bus(1'b1, OFS_CMD, 32'(OP_PROG));
    bus(1'b1, OFS_CMD, 32'(OP_CHIP));
    bus(1'b0, OFS_CMD, 32'h0);
    chk("cmd", 32'(OP_PROG), q);
    poll();
    bus(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", 32'h77, q);
    // Slow erase: controller gives up, then host keeps reading
    slow <= 1'b1;
    op(OP_SECT, 21'h00200, 8'h00);
    chk("status", DONE | (32'h1 << ST_TOUT_BIT), q);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk("bit7", 32'h0, q & 32'h80);
    bus(1'b1, OFS_STATUS, 32'h6);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status clear", 32'h0, q);
    slow <= 1'b0;
    n = 0;
    do begin
      op(OP_READ, 21'h00200, 8'h00);
      bus(1'b0, OFS_RDATA, 32'h0);
      n++;
    end while (q !== 32'hFF && n < 60);
    chk("erased", 32'hFF, q);
    // Unmapped place reads zero, write has no effect
    bus(1'b1, 5'h14, 32'hFFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    close_out();
  end
endmodule
